// >>> rtl/conv_sync_dev.sv
// converter end: slave link on the link clock, conversion timing on the oscillator
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: finished device accepts a write without readout
// R2: Stop after acked write starts new conversion
// R3: bytes written before Stop configure next conversion
// R4: master syncs only when all converters idle
// R5: global write address is acked by everyone
// R6: global write byte applies, Stop starts conversion
// R7: bare global Stop keeps existing configuration
// R8: global read address is always not-acknowledged
// R9: sampling switches toggle at set rate
// R10: after conversion device sleeps, ready for access
// R11: own address while converting is not-acknowledged
// R12: read start conversion after 24 bits or Stop
// R13: offset calibration phase in every conversion cycle
// R14: foreign addresses are ignored, state kept
module conv_sync_dev #(
	parameter int unsigned CONV_CYCLES = conv_sync_pkg::CONV_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	twi_link.dev bus,
	input wire logic [6:0] dev_addr_i,
	input wire logic [23:0] sample_i,
	output logic busy_o,
	output logic conv_start_o,
	output logic [7:0] chan_o,
	output logic [7:0] mode_o,
	output logic samp_sw_o,
	output logic cal_o
);
	localparam int unsigned CAL_CYCLES = CONV_CYCLES / conv_sync_pkg::CAL_DIV;

	// link domain
	conv_sync_pkg::link_st_t lst_r;
	logic scl_s1, scl_s2, scl_s3;
	logic sda_s1, sda_s2, sda_s3;
	logic done_s1, done_s2;
	logic [6:0] addr_s1, addr_s2;
	logic [3:0] bits_r;
	logic [7:0] shift_r, chan_r, mode_r;
	logic [1:0] nbytes_r;
	logic [23:0] tx_r;
	logic rw_r, glob_r, pend_r, wait_r, go_tgl_r, sda_oe_r;
	logic scl_rise, scl_fall, start_ev, stop_ev;
	logic addr_glob, addr_own, addr_ok;

	// oscillator domain
	logic go_s1, go_s2, go_s3, go_ev, done_r;
	logic [conv_sync_pkg::CNT_W-1:0] cnt_r;
	logic [8:0] sw_cnt_r;
	logic [23:0] result_r;

	assign bus.sda_d_o = 1'b0;
	assign bus.sda_d_oe = sda_oe_r;

	////////////////////////////////////////////////////////////////////////
	// link side: pin sync and bus condition detect

	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
			{done_s1, done_s2} <= 2'h0;
			{addr_s1, addr_s2} <= 14'h0000;
		end else begin
			{scl_s1, scl_s2, scl_s3} <= {bus.scl, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_s3} <= {bus.sda, sda_s1, sda_s2};
			{done_s1, done_s2} <= {done_r, done_s1};
			{addr_s1, addr_s2} <= {dev_addr_i, addr_s1};
		end
	end

	assign scl_rise = scl_s2 && !scl_s3;
	assign scl_fall = !scl_s2 && scl_s3;
	assign start_ev = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
	assign stop_ev = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

	assign addr_glob = (shift_r[7:1] == conv_sync_pkg::GLOBAL_ADDR);
	assign addr_own = (shift_r[7:1] == addr_s2);
	// ack only a sleeping device; global only with write direction
	assign addr_ok = done_s2 && !wait_r
		&& (addr_own || (addr_glob && !shift_r[0])); // [R1] [R5] [R8] [R10] [R11]

	////////////////////////////////////////////////////////////////////////
	// link side: slave transfer sequencer

	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lst_r <= conv_sync_pkg::L_IDLE;
			bits_r <= 4'h0;
			shift_r <= 8'h00;
			nbytes_r <= 2'h0;
			tx_r <= 24'h000000;
			chan_r <= conv_sync_pkg::DEF_CHAN;
			mode_r <= conv_sync_pkg::DEF_MODE;
			rw_r <= 1'b0;
			glob_r <= 1'b0;
			pend_r <= 1'b0;
			wait_r <= 1'b0;
			go_tgl_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else begin
			// hides the few cycles before the oscillator side drops done
			wait_r <= wait_r && done_s2;
			if (start_ev) begin
				// a repeated start keeps a pending start-on-Stop
				lst_r <= conv_sync_pkg::L_ADDR;
				bits_r <= 4'h0;
				nbytes_r <= 2'h0;
				sda_oe_r <= 1'b0;
			end else if (stop_ev) begin
				lst_r <= conv_sync_pkg::L_IDLE;
				sda_oe_r <= 1'b0;
				pend_r <= 1'b0;
				go_tgl_r <= go_tgl_r ^ pend_r; // [R2] [R6] [R7] [R12]
				wait_r <= pend_r || (wait_r && done_s2);
			end else begin
				unique case (lst_r)
					conv_sync_pkg::L_ADDR: begin
						if (scl_rise) begin
							shift_r <= {shift_r[6:0], sda_s2};
							bits_r <= bits_r + 4'h1;
						end else if (scl_fall && bits_r == conv_sync_pkg::BYTE_BITS) begin
							rw_r <= shift_r[0];
							glob_r <= addr_glob;
							tx_r <= result_r;
							if (addr_ok) begin
								sda_oe_r <= 1'b1;
								lst_r <= conv_sync_pkg::L_AACK;
							end else begin
								lst_r <= conv_sync_pkg::L_SKIP; // [R14]
							end
						end
					end
					conv_sync_pkg::L_AACK: begin
						if (scl_fall) begin
							bits_r <= 4'h0;
							pend_r <= 1'b1; // [R2] [R12]
							sda_oe_r <= rw_r && !tx_r[23];
							lst_r <= rw_r ? conv_sync_pkg::L_RD : conv_sync_pkg::L_WR;
						end
					end
					conv_sync_pkg::L_WR: begin
						if (scl_rise) begin
							shift_r <= {shift_r[6:0], sda_s2};
							bits_r <= bits_r + 4'h1;
						end else if (scl_fall && bits_r == conv_sync_pkg::BYTE_BITS) begin
							// a global call carries at most one byte
							if ((glob_r && nbytes_r != 2'h0) || nbytes_r == conv_sync_pkg::CFG_BYTES) begin
								lst_r <= conv_sync_pkg::L_SKIP;
							end else begin
								if (nbytes_r == 2'h0) begin
									chan_r <= shift_r; // [R3] [R6]
								end else begin
									mode_r <= shift_r; // [R3]
								end
								nbytes_r <= nbytes_r + 2'h1;
								sda_oe_r <= 1'b1;
								lst_r <= conv_sync_pkg::L_WACK;
							end
						end
					end
					conv_sync_pkg::L_WACK: begin
						if (scl_fall) begin
							sda_oe_r <= 1'b0;
							bits_r <= 4'h0;
							lst_r <= conv_sync_pkg::L_WR;
						end
					end
					conv_sync_pkg::L_RD: begin
						if (scl_rise) begin
							bits_r <= bits_r + 4'h1;
						end else if (scl_fall) begin
							tx_r <= {tx_r[22:0], 1'b0};
							if (bits_r == conv_sync_pkg::BYTE_BITS) begin
								sda_oe_r <= 1'b0;
								nbytes_r <= nbytes_r + 2'h1;
								lst_r <= conv_sync_pkg::L_RACK;
							end else begin
								sda_oe_r <= !tx_r[22];
							end
						end
					end
					conv_sync_pkg::L_RACK: begin
						if (scl_rise) begin
							if (nbytes_r == conv_sync_pkg::RES_BYTES) begin
								go_tgl_r <= !go_tgl_r; // [R12]
								wait_r <= 1'b1;
								pend_r <= 1'b0;
								lst_r <= conv_sync_pkg::L_SKIP;
							end else if (sda_s2) begin
								lst_r <= conv_sync_pkg::L_SKIP;
							end
						end else if (scl_fall) begin
							sda_oe_r <= !tx_r[23];
							bits_r <= 4'h0;
							lst_r <= conv_sync_pkg::L_RD;
						end
					end
					conv_sync_pkg::L_IDLE, conv_sync_pkg::L_SKIP: begin
						sda_oe_r <= 1'b0;
					end
					default: lst_r <= conv_sync_pkg::L_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// oscillator side: start event crossing and conversion timing

	// chan_r/mode_r are stable here: the device naks writes until done again
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			{go_s1, go_s2, go_s3} <= 3'h0;
		end else begin
			{go_s1, go_s2, go_s3} <= {go_tgl_r, go_s1, go_s2};
		end
	end

	assign go_ev = go_s2 ^ go_s3;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_o <= 1'b1;
			done_r <= 1'b0;
			cnt_r <= '0;
			cal_o <= 1'b1;
			conv_start_o <= 1'b0;
			chan_o <= conv_sync_pkg::DEF_CHAN;
			mode_o <= conv_sync_pkg::DEF_MODE;
			result_r <= 24'h000000;
		end else begin
			conv_start_o <= 1'b0;
			if (go_ev) begin
				busy_o <= 1'b1;
				done_r <= 1'b0;
				cnt_r <= '0;
				cal_o <= 1'b1; // [R13]
				conv_start_o <= 1'b1;
				chan_o <= chan_r; // [R3] [R6] [R7]
				mode_o <= mode_r;
			end else if (busy_o) begin
				cal_o <= cal_o && (cnt_r != conv_sync_pkg::CNT_W'(CAL_CYCLES - 1)); // [R13]
				if (cnt_r == conv_sync_pkg::CNT_W'(CONV_CYCLES - 1)) begin
					// result is held until the next conversion ends so the link may read it
					busy_o <= 1'b0;
					done_r <= 1'b1; // [R10]
					result_r <= sample_i;
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sw_cnt_r <= 9'h000;
			samp_sw_o <= 1'b0;
		end else if (!busy_o || sw_cnt_r == 9'(conv_sync_pkg::SW_HALF_CYC - 1)) begin
			sw_cnt_r <= 9'h000;
			samp_sw_o <= busy_o && !samp_sw_o; // [R9]
		end else begin
			sw_cnt_r <= sw_cnt_r + 9'h001;
		end
	end
endmodule : conv_sync_dev
`default_nettype wire

// >>> pkg/conv_sync_pkg.sv
// shared constants and types for the conversion-start two-wire link
package conv_sync_pkg;

	// system clock and link bit rate
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned SCL_HZ = 100_000;
	localparam int unsigned QUARTER_CYC = CLK_HZ / (4 * SCL_HZ);
	localparam int unsigned Q_W = 8;

	// shared synchronisation address, write direction only
	localparam logic [6:0] GLOBAL_ADDR = 7'h77;

	// input sampling switch rate on the internal oscillator
	localparam int unsigned SW_HZ = 123_000;
	localparam int unsigned SW_HALF_CYC = CLK_HZ / (2 * SW_HZ);

	// conversion length in oscillator periods and the oscillator rate
	localparam longint unsigned CONV_OSC_CYC = 41036;
	localparam longint unsigned OSC_HZ = 307_200;
	localparam int unsigned CONV_CYC = int'((longint'(CLK_HZ) * CONV_OSC_CYC) / OSC_HZ);
	localparam int unsigned CAL_DIV = 8;
	localparam int unsigned CNT_W = 23;

	// result and configuration
	localparam int unsigned RES_W = 24;
	localparam logic [7:0] DEF_CHAN = 8'h00;
	localparam logic [7:0] DEF_MODE = 8'h00;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [1:0] RES_BYTES = 2'h3;
	localparam logic [1:0] CFG_BYTES = 2'h2;

	typedef enum logic [1:0] {
		OP_WRITE = 2'h0,
		OP_SYNC = 2'h1,
		OP_READ = 2'h2,
		OP_GREAD = 2'h3
	} op_t;

	typedef enum logic [7:0] {
		L_IDLE = 8'h01,
		L_ADDR = 8'h02,
		L_AACK = 8'h04,
		L_WR = 8'h08,
		L_WACK = 8'h10,
		L_RD = 8'h20,
		L_RACK = 8'h40,
		L_SKIP = 8'h80
	} link_st_t;

	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_START = 4'h2,
		H_BIT = 4'h4,
		H_STOP = 4'h8
	} host_st_t;

endpackage : conv_sync_pkg

// >>> pkg/twi_link.sv
// open-drain two-wire link joining the bus master and the converter
`timescale 1ns/1ps
`default_nettype none
interface twi_link;
	logic scl_h_o;
	logic scl_h_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl;
	logic sda;

	// pull-up: a line is low only while some driver enables a low
	assign scl = (scl_h_oe && !scl_h_o) ? 1'b0 : 1'b1;
	assign sda = ((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o)) ? 1'b0 : 1'b1;

	modport host (
		output scl_h_o,
		output scl_h_oe,
		output sda_h_o,
		output sda_h_oe,
		input scl,
		input sda
	);

	modport dev (
		output sda_d_o,
		output sda_d_oe,
		input scl,
		input sda
	);
endinterface : twi_link
`default_nettype wire

// >>> rtl/conv_sync_host.sv
// bus master end: issues discard/write, global sync, read and global read frames
`timescale 1ns/1ps
`default_nettype none
module conv_sync_host (
	input wire logic clk_i,
	input wire logic rst_i,
	twi_link.host bus,
	input wire logic cmd_valid_i,
	input wire logic [1:0] cmd_op_i,
	input wire logic [6:0] cmd_addr_i,
	input wire logic cmd_has_byte_i,
	input wire logic [7:0] cmd_byte_i,
	input wire logic peers_idle_i,
	output logic cmd_ready_o,
	output logic done_o,
	output logic nak_o,
	output logic [23:0] rdata_o
);
	conv_sync_pkg::host_st_t st_r;
	logic [conv_sync_pkg::Q_W-1:0] q_r;
	logic [1:0] ph_r;
	logic [3:0] bit_r;
	logic [1:0] byte_r;
	logic [1:0] last_r;
	logic [1:0] op_r;
	logic [7:0] tx_r;
	logic [7:0] data_r;
	logic [23:0] rx_r;
	logic scl_oe_r;
	logic sda_oe_r;
	logic sda_s1;
	logic sda_s2;
	logic tick;
	logic rx_byte;
	logic accept;
	logic rd_dir;

	assign bus.scl_h_o = 1'b0;
	assign bus.sda_h_o = 1'b0;
	assign bus.scl_h_oe = scl_oe_r;
	assign bus.sda_h_oe = sda_oe_r;

	assign tick = (q_r == '0);
	assign rx_byte = (byte_r != 2'h0) && (op_r == conv_sync_pkg::OP_READ);
	assign rd_dir = (cmd_op_i == conv_sync_pkg::OP_READ) || (cmd_op_i == conv_sync_pkg::OP_GREAD);
	// a global sync waits until every converter on the bus has finished
	assign accept = cmd_valid_i && cmd_ready_o
		&& ((cmd_op_i != conv_sync_pkg::OP_SYNC) || peers_idle_i); // [R4]

	////////////////////////////////////////////////////////////////////////
	// input sync and bit-time divider

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end else begin
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q_r <= conv_sync_pkg::Q_W'(conv_sync_pkg::QUARTER_CYC - 1);
		end else if (st_r == conv_sync_pkg::H_IDLE || tick) begin
			q_r <= conv_sync_pkg::Q_W'(conv_sync_pkg::QUARTER_CYC - 1);
		end else begin
			q_r <= q_r - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame sequencer

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= conv_sync_pkg::H_IDLE;
			ph_r <= 2'h0;
			bit_r <= 4'h0;
			byte_r <= 2'h0;
			last_r <= 2'h0;
			op_r <= 2'h0;
			tx_r <= 8'h00;
			data_r <= 8'h00;
			rx_r <= 24'h000000;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			cmd_ready_o <= 1'b0;
			done_o <= 1'b0;
			nak_o <= 1'b0;
			rdata_o <= 24'h000000;
		end else begin
			done_o <= 1'b0;
			unique case (st_r)
				conv_sync_pkg::H_IDLE: begin
					cmd_ready_o <= 1'b1;
					if (accept) begin
						cmd_ready_o <= 1'b0;
						nak_o <= 1'b0;
						op_r <= cmd_op_i;
						data_r <= cmd_byte_i;
						byte_r <= 2'h0;
						bit_r <= 4'h0;
						ph_r <= 2'h0;
						// global frames use the shared address [R5]
						if (cmd_op_i == conv_sync_pkg::OP_SYNC || cmd_op_i == conv_sync_pkg::OP_GREAD) begin
							tx_r <= {conv_sync_pkg::GLOBAL_ADDR, rd_dir};
						end else begin
							tx_r <= {cmd_addr_i, rd_dir};
						end
						// optional byte, else Stop right after the address ack [R3] [R6] [R7]
						if (cmd_op_i == conv_sync_pkg::OP_READ) begin
							last_r <= conv_sync_pkg::RES_BYTES;
						end else if (cmd_op_i != conv_sync_pkg::OP_GREAD && cmd_has_byte_i) begin
							last_r <= 2'h1;
						end else begin
							last_r <= 2'h0;
						end
						st_r <= conv_sync_pkg::H_START;
					end
				end
				conv_sync_pkg::H_START: begin
					if (tick) begin
						if (ph_r == 2'h0) begin
							sda_oe_r <= 1'b1;
							ph_r <= 2'h1;
						end else begin
							scl_oe_r <= 1'b1;
							ph_r <= 2'h0;
							st_r <= conv_sync_pkg::H_BIT;
						end
					end
				end
				conv_sync_pkg::H_BIT: begin
					if (tick) begin
						ph_r <= ph_r + 2'h1;
						unique case (ph_r)
							2'h0: begin
								if (bit_r == conv_sync_pkg::BYTE_BITS) begin
									// ack every result byte but the last
									sda_oe_r <= rx_byte && (byte_r != last_r);
								end else begin
									sda_oe_r <= rx_byte ? 1'b0 : !tx_r[7];
								end
							end
							2'h1: scl_oe_r <= 1'b0;
							2'h2: begin
								if (bit_r != conv_sync_pkg::BYTE_BITS) begin
									if (rx_byte) begin
										rx_r <= {rx_r[22:0], sda_s2};
									end else begin
										tx_r <= {tx_r[6:0], 1'b0};
									end
								end else if (!rx_byte && sda_s2) begin
									nak_o <= 1'b1;
								end
							end
							2'h3: begin
								scl_oe_r <= 1'b1;
								if (bit_r == conv_sync_pkg::BYTE_BITS) begin
									bit_r <= 4'h0;
									if (nak_o || byte_r == last_r) begin
										st_r <= conv_sync_pkg::H_STOP;
									end else begin
										byte_r <= byte_r + 2'h1;
										tx_r <= data_r;
									end
								end else begin
									bit_r <= bit_r + 4'h1;
								end
							end
						endcase
					end
				end
				conv_sync_pkg::H_STOP: begin
					if (tick) begin
						ph_r <= ph_r + 2'h1;
						unique case (ph_r)
							2'h0: sda_oe_r <= 1'b1;
							2'h1: scl_oe_r <= 1'b0;
							2'h2: sda_oe_r <= 1'b0;
							2'h3: begin
								st_r <= conv_sync_pkg::H_IDLE;
								done_o <= 1'b1;
								rdata_o <= rx_r;
							end
						endcase
					end
				end
				default: st_r <= conv_sync_pkg::H_IDLE;
			endcase
		end
	end
endmodule : conv_sync_host
`default_nettype wire

// >>> sim/conv_sync_checker.sv
// concurrent checks on the link wires and the converter's conversion outputs
`timescale 1ns/1ps
`default_nettype none
module conv_sync_checker #(
	parameter int unsigned CONV_CYCLES = 4000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_d_oe,
	input wire logic busy_o,
	input wire logic conv_start_o,
	input wire logic [7:0] chan_o,
	input wire logic samp_sw_o,
	input wire logic cal_o
);
	logic [22:0] conv_cnt_r;
	logic [8:0] sw_cnt_r;
	logic sw_q_r;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i || !busy_o || conv_start_o) begin
			conv_cnt_r <= '0;
		end else begin
			conv_cnt_r <= conv_cnt_r + 23'h1;
		end
	end
	// cycles since the switches last moved, counted only while converting
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i || !busy_o || (samp_sw_o != sw_q_r)) begin
			sw_cnt_r <= '0;
		end else begin
			sw_cnt_r <= sw_cnt_r + 9'h1;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sw_q_r <= 1'b0;
		end else begin
			sw_q_r <= samp_sw_o;
		end
	end
	////////////////////////////////////////////////////////////////
	sequence s_busy_run;
		busy_o [*8];
	endsequence
	sequence s_cal_run;
		cal_o [*8];
	endsequence
	property p_sw_rate;
		@(posedge clk_i) disable iff (rst_i) busy_o |-> sw_cnt_r <= conv_sync_pkg::SW_HALF_CYC;
	endproperty
	a_sw_rate: assert property (p_sw_rate) else $error("sampling switch period too long");
	property p_sw_idle;
		@(posedge clk_i) disable iff (rst_i) !busy_o && !$past(busy_o) |-> !samp_sw_o;
	endproperty
	a_sw_idle: assert property (p_sw_idle) else $error("sampling switch moves while asleep");
	property p_cal_on;
		@(posedge clk_i) disable iff (rst_i) conv_start_o |=> s_cal_run;
	endproperty
	a_cal_on: assert property (p_cal_on) else $error("calibration missing at start");
	property p_cal_off;
		@(posedge clk_i) disable iff (rst_i) busy_o && conv_cnt_r > CONV_CYCLES / 8 + 4 |-> !cal_o;
	endproperty
	a_cal_off: assert property (p_cal_off) else $error("calibration window too long");
	property p_start_busy;
		@(posedge clk_i) disable iff (rst_i) conv_start_o |-> s_busy_run;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start without busy");
	property p_busy_len;
		@(posedge clk_i) disable iff (rst_i) busy_o |-> conv_cnt_r <= CONV_CYCLES + 4;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("conversion never ends");
	property p_start_idle;
		@(posedge clk_i) disable iff (rst_i) conv_start_o |-> !$past(busy_o) ##1 !conv_start_o;
	endproperty
	a_start_idle: assert property (p_start_idle) else $error("start while converting");
	property p_cfg_at_start;
		@(posedge clk_i) disable iff (rst_i) $changed(chan_o) |-> conv_start_o;
	endproperty
	a_cfg_at_start: assert property (p_cfg_at_start) else $error("channel moved mid-run");
	property p_sda_scl_low;
		@(posedge link_clk_i) disable iff (rst_i) $changed(sda_d_oe) |-> !scl;
	endproperty
	a_sda_scl_low: assert property (p_sda_scl_low) else $error("device moved sda at scl high");
endmodule : conv_sync_checker
`default_nettype wire

// >>> sim/adc_conversion_start_sync_bench.sv
// bench: bus master end facing one converter end over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_start_sync_bench;
	localparam int unsigned CONV = 4000;
	localparam logic [6:0] ADDR = 7'h14;
	localparam logic [23:0] SAMPLE = 24'hc3a51e;
	logic clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cmd_valid = 1'b0;
	logic [1:0] cmd_op = 2'h0;
	logic [6:0] cmd_addr = 7'h00;
	logic cmd_has_byte = 1'b0;
	logic [7:0] cmd_byte = 8'h00;
	logic peers_idle, cmd_ready, done, nak, busy, conv_start, samp_sw, cal;
	logic [23:0] rdata;
	logic [7:0] chan, mode;
	logic [7:0] addr_sh = 8'h00;
	int addr_bits = 0;
	int n_starts = 0;
	int seen_starts = 0;
	int err_count = 0;
	int n_tests = 0;
	twi_link tl();
	////////////////////////////////////////////////////////////////
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		#7.3;
		forever #24 link_clk_i = ~link_clk_i;
	end
	// a global call waits until every converter has finished
	assign peers_idle = !busy;
	conv_sync_host u_conv_sync_host (.clk_i(clk_i), .rst_i(rst_i), .bus(tl.host),
		.cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr),
		.cmd_has_byte_i(cmd_has_byte), .cmd_byte_i(cmd_byte), .peers_idle_i(peers_idle),
		.cmd_ready_o(cmd_ready), .done_o(done), .nak_o(nak), .rdata_o(rdata));
	conv_sync_dev #(.CONV_CYCLES(CONV)) u_conv_sync_dev (.clk_i(clk_i), .rst_i(rst_i),
		.link_clk_i(link_clk_i), .bus(tl.dev), .dev_addr_i(ADDR), .sample_i(SAMPLE),
		.busy_o(busy), .conv_start_o(conv_start), .chan_o(chan), .mode_o(mode),
		.samp_sw_o(samp_sw), .cal_o(cal));
	conv_sync_checker #(.CONV_CYCLES(CONV)) u_conv_sync_checker (.clk_i(clk_i), .rst_i(rst_i),
		.link_clk_i(link_clk_i), .scl(tl.scl), .sda(tl.sda), .sda_d_oe(tl.sda_d_oe),
		.busy_o(busy), .conv_start_o(conv_start), .chan_o(chan), .samp_sw_o(samp_sw),
		.cal_o(cal));
	// first byte after each start, as seen on the wire
	always @(negedge tl.sda) if (tl.scl === 1'b1) n_starts++;
	always @(posedge tl.scl) begin
		if (seen_starts != n_starts) begin
			seen_starts = n_starts;
			addr_bits = 0;
		end
		if (addr_bits < 8) begin
			addr_sh = {addr_sh[6:0], tl.sda};
			addr_bits++;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
			err_count++;
		end
	endtask : chk_bit
	task automatic chk_word(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask : chk_word
	task automatic give_up(input string what);
		$display("CHECK FAILED %s expected done seen timeout", what);
		err_count++;
		report_and_stop();
	endtask : give_up
	// one frame: present the command until taken, then wait for its end
	task automatic do_cmd(input logic [1:0] op, input logic [6:0] a, input logic hb,
			input logic [7:0] b);
		int i;
		logic go;
		@(posedge clk_i);
		#1;
		cmd_op = op;
		cmd_addr = a;
		cmd_has_byte = hb;
		cmd_byte = b;
		cmd_valid = 1'b1;
		// ready and peers_idle stand until the edge that takes the command
		for (i = 0; i < 20000; i++) begin
			go = (cmd_ready === 1'b1) && (op != 2'h1 || peers_idle === 1'b1);
			@(posedge clk_i);
			#1;
			if (go) break;
		end
		if (i == 20000) give_up("accept");
		cmd_valid = 1'b0;
		for (i = 0; i < 20000; i++) begin
			if (done === 1'b1) break;
			@(posedge clk_i);
			#1;
		end
		if (i == 20000) give_up("frame");
		repeat (10) @(posedge clk_i);
		#1;
	endtask : do_cmd
	task automatic wait_idle();
		int i;
		for (i = 0; i < CONV + 100; i++) begin
			if (busy === 1'b0) break;
			@(posedge clk_i);
			#1;
		end
		if (i == CONV + 100) give_up("conversion end");
	endtask : wait_idle
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		do_cmd(2'h0, ADDR, 1'b0, 8'h00);
		chk_bit("nak while converting", 1'b1, nak);
		wait_idle();
		$display("test busy_refusal done");
		do_cmd(2'h2, ADDR, 1'b0, 8'h00);
		chk_bit("read nak", 1'b0, nak);
		chk_word("read data", SAMPLE, rdata);
		chk_bit("busy after read", 1'b1, busy);
		wait_idle();
		$display("test read_restart done");
		do_cmd(2'h0, ADDR, 1'b1, 8'h5a);
		chk_bit("write nak", 1'b0, nak);
		chk_bit("busy after write", 1'b1, busy);
		chk_word("channel", 24'h00005a, {16'h0000, chan});
		chk_word("mode kept", {16'h0000, conv_sync_pkg::DEF_MODE}, {16'h0000, mode});
		wait_idle();
		do_cmd(2'h0, ADDR, 1'b0, 8'h00);
		chk_bit("busy after discard", 1'b1, busy);
		chk_word("channel kept", 24'h00005a, {16'h0000, chan});
		wait_idle();
		$display("test own_write done");
		do_cmd(2'h0, 7'h11, 1'b1, 8'ha5);
		chk_bit("foreign nak", 1'b1, nak);
		chk_bit("busy after foreign", 1'b0, busy);
		chk_word("channel after foreign", 24'h00005a, {16'h0000, chan});
		do_cmd(2'h3, conv_sync_pkg::GLOBAL_ADDR, 1'b0, 8'h00);
		chk_word("global read address", {16'h0000, conv_sync_pkg::GLOBAL_ADDR, 1'b1},
			{16'h0000, addr_sh});
		chk_bit("global read nak", 1'b1, nak);
		chk_bit("busy after global read", 1'b0, busy);
		$display("test refusals done");
		do_cmd(2'h1, conv_sync_pkg::GLOBAL_ADDR, 1'b1, 8'h3c);
		chk_word("global write address", {16'h0000, conv_sync_pkg::GLOBAL_ADDR, 1'b0},
			{16'h0000, addr_sh});
		chk_bit("global nak", 1'b0, nak);
		chk_bit("busy after global", 1'b1, busy);
		chk_word("global channel", 24'h00003c, {16'h0000, chan});
		wait_idle();
		do_cmd(2'h1, conv_sync_pkg::GLOBAL_ADDR, 1'b0, 8'h00);
		chk_bit("bare global busy", 1'b1, busy);
		chk_word("bare global channel", 24'h00003c, {16'h0000, chan});
		// issued while converting: the master must hold it back until idle
		do_cmd(2'h1, conv_sync_pkg::GLOBAL_ADDR, 1'b0, 8'h00);
		chk_bit("held global nak", 1'b0, nak);
		chk_bit("held global busy", 1'b1, busy);
		wait_idle();
		$display("test global_sync done");
		report_and_stop();
	end
endmodule : adc_conversion_start_sync_bench
`default_nettype wire
